// ### inc/pressure_fetch_defines.svh
// Constants of the pressure sensor fetch interface
`ifndef PRESSURE_FETCH_DEFINES_SVH
`define PRESSURE_FETCH_DEFINES_SVH

`define TARGET_ADDR 7'h28
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define BYTE_FIRST 3'h0
`define BYTE_PRES_LOW 3'h1
`define BYTE_TEMP_HIGH 3'h2
`define BYTE_TEMP_LOW 3'h3
`define BYTE_BEYOND 3'h4
`define BYTE_FILL 8'h00
`define TEMP_LOW_PAD 5'h00
`define NEGATIVE_FULL_SCALE_CODE 14'h0666
`define POSITIVE_FULL_SCALE_CODE 14'h3999
`define FULL_SCALE_SPAN 14'h3333
`define STAT_NORMAL 2'h0
`define STAT_COMMAND 2'h1
`define STAT_STALE 2'h2
`define STAT_FAULT 2'h3
`define FIFO_DEPTH 2'h2
`define FIFO_EMPTY 2'h0

`endif

// ### inc/pressure_fetch_pkg.sv
// Types of the pressure sensor fetch interface
package pressure_fetch_pkg;

  typedef struct packed {
    logic fault;
    logic [13:0] pres;
    logic [10:0] temp;
  } meas_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_ACK_ADDR = 5'h04,
    ST_TX = 5'h08,
    ST_CTRL_ACK = 5'h10
  } fetch_state_e;

endpackage

// ### verilog/pressure_fetch.sv
// I2C read-only target returning pressure and temperature packets
`timescale 1ns/100ps
`include "pressure_fetch_defines.svh"
module pressure_fetch (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic meas_valid_i,
  input wire pressure_fetch_pkg::meas_s meas_i,
  output logic meas_ready_o,
  input wire logic cmd_mode_i
);

  // Link side: capture data bit on each rising serial clock
  logic sda_cap_q;
  logic bit_tgl_q;

  always_ff @(posedge scl_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_cap_q <= 1'b0;
      bit_tgl_q <= 1'b0;
    end else begin
      sda_cap_q <= sda_i;
      bit_tgl_q <= ~bit_tgl_q;
    end
  end

  // Pin and toggle synchronisers
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic [2:0] tgl_s_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      tgl_s_q <= 3'h0;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      tgl_s_q <= {tgl_s_q[1:0], bit_tgl_q};
    end
  end

  logic bit_ev;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic bit_val;

  assign bit_ev = tgl_s_q[2] ^ tgl_s_q[1];
  // Captured bit is held steady until the next rising edge
  assign bit_val = sda_cap_q;
  assign scl_fall = scl_s_q[2] & ~scl_s_q[1];
  assign start_ev = scl_s_q[1] & scl_s_q[2] & sda_s_q[2] & ~sda_s_q[1];
  assign stop_ev = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[2] & sda_s_q[1];

  // Two-entry measurement buffer
  pressure_fetch_pkg::meas_s mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;
  logic fifo_valid;

  assign fifo_valid = (count_q != `FIFO_EMPTY);
  assign meas_ready_o = (count_q != `FIFO_DEPTH);
  assign push = meas_valid_i & meas_ready_o;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= `FIFO_EMPTY;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop && fifo_valid) rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop & fifo_valid};
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem_q[wr_ptr_q] <= meas_i;
  end

  // Transfer state
  pressure_fetch_pkg::fetch_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [2:0] byte_idx_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] addr_byte;
  logic addr_hit;

  assign addr_byte = {shift_q[6:0], bit_val};
  assign addr_hit = (addr_byte[7:1] == `TARGET_ADDR) & addr_byte[0];
  assign pop = (state_q == pressure_fetch_pkg::ST_ACK_ADDR) & scl_fall
    & ~sda_oe_o;

  // Held sample, stale and fault status
  pressure_fetch_pkg::meas_s cur_q;
  logic stale_q;
  logic fault_q;
  logic [1:0] status;
  logic [13:0] pres_out;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_q <= '0;
      stale_q <= 1'b1;
      fault_q <= 1'b0;
    end else if (pop) begin
      stale_q <= ~fifo_valid;
      if (fifo_valid) begin
        cur_q <= mem_q[rd_ptr_q];
        fault_q <= fault_q | mem_q[rd_ptr_q].fault;
      end
    end
  end

  assign status = fault_q ? `STAT_FAULT
    : cmd_mode_i ? `STAT_COMMAND : stale_q ? `STAT_STALE : `STAT_NORMAL;

  // Pressure code held inside the full-scale span
  assign pres_out = (cur_q.pres < `NEGATIVE_FULL_SCALE_CODE)
    ? `NEGATIVE_FULL_SCALE_CODE : (cur_q.pres > `POSITIVE_FULL_SCALE_CODE)
    ? `POSITIVE_FULL_SCALE_CODE : cur_q.pres;

  function automatic logic [7:0] pkt_byte(input logic [2:0] idx);
    case (idx)
      `BYTE_FIRST: pkt_byte = {status, pres_out[13:8]};
      `BYTE_PRES_LOW: pkt_byte = pres_out[7:0];
      `BYTE_TEMP_HIGH: pkt_byte = cur_q.temp[10:3];
      `BYTE_TEMP_LOW: pkt_byte = {cur_q.temp[2:0], `TEMP_LOW_PAD};
      default: pkt_byte = `BYTE_FILL;
    endcase
  endfunction

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= pressure_fetch_pkg::ST_IDLE;
    end else if (start_ev) begin
      state_q <= pressure_fetch_pkg::ST_ADDR;
    end else if (stop_ev) begin
      state_q <= pressure_fetch_pkg::ST_IDLE;
    end else if (bit_ev) begin
      unique case (state_q)
        pressure_fetch_pkg::ST_IDLE: state_q <= pressure_fetch_pkg::ST_IDLE;
        pressure_fetch_pkg::ST_ADDR: begin
          if (bit_cnt_q == `BIT_LAST) begin
            state_q <= addr_hit ? pressure_fetch_pkg::ST_ACK_ADDR
              : pressure_fetch_pkg::ST_IDLE;
          end
        end
        pressure_fetch_pkg::ST_ACK_ADDR: state_q <= pressure_fetch_pkg::ST_TX;
        pressure_fetch_pkg::ST_TX: begin
          if (bit_cnt_q == `BIT_FIRST) begin
            state_q <= pressure_fetch_pkg::ST_CTRL_ACK;
          end
        end
        pressure_fetch_pkg::ST_CTRL_ACK: begin
          state_q <= bit_val ? pressure_fetch_pkg::ST_IDLE
            : pressure_fetch_pkg::ST_TX;
        end
      endcase
    end
  end

  // Bit and byte counters, address shifter, transmit byte
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_q <= `BIT_FIRST;
      byte_idx_q <= `BYTE_FIRST;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
    end else if (start_ev) begin
      bit_cnt_q <= `BIT_FIRST;
      byte_idx_q <= `BYTE_FIRST;
    end else if (bit_ev) begin
      unique case (state_q)
        pressure_fetch_pkg::ST_ADDR: begin
          shift_q <= addr_byte;
          bit_cnt_q <= bit_cnt_q + 3'h1;
        end
        pressure_fetch_pkg::ST_ACK_ADDR: begin
          tx_q <= pkt_byte(`BYTE_FIRST);
          bit_cnt_q <= `BIT_LAST;
        end
        pressure_fetch_pkg::ST_TX: bit_cnt_q <= bit_cnt_q - 3'h1;
        pressure_fetch_pkg::ST_CTRL_ACK: begin
          if (!bit_val && byte_idx_q != `BYTE_BEYOND) begin
            byte_idx_q <= byte_idx_q + 3'h1;
            tx_q <= pkt_byte(byte_idx_q + 3'h1);
          end else begin
            tx_q <= `BYTE_FILL;
          end
          bit_cnt_q <= `BIT_LAST;
        end
        default: bit_cnt_q <= bit_cnt_q;
      endcase
    end
  end

  // Open-drain data line: only ever pulled low
  assign sda_o = 1'b0;
  logic sda_oe_q;
  assign sda_oe_o = sda_oe_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_oe_q <= 1'b0;
    end else if (start_ev || stop_ev) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      unique case (state_q)
        pressure_fetch_pkg::ST_ACK_ADDR: sda_oe_q <= 1'b1;
        pressure_fetch_pkg::ST_TX: sda_oe_q <= ~tx_q[bit_cnt_q];
        default: sda_oe_q <= 1'b0;
      endcase
    end
  end

  // Checks
  default clocking chk_clk @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  chk_foreign_addr: assert property (bit_ev && !start_ev && !stop_ev
    && state_q == pressure_fetch_pkg::ST_ADDR && bit_cnt_q == `BIT_LAST
    && !addr_hit |=> state_q == pressure_fetch_pkg::ST_IDLE)
    else $error("foreign address not ignored");
  chk_ack_driven: assert property (scl_fall && !start_ev && !stop_ev
    && state_q == pressure_fetch_pkg::ST_ACK_ADDR |=> sda_oe_o)
    else $error("address not acknowledged");
  chk_first_byte: assert property (bit_ev && !start_ev && !stop_ev
    && state_q == pressure_fetch_pkg::ST_ACK_ADDR
    |=> tx_q == {$past(status), $past(pres_out[13:8])})
    else $error("first byte wrong");
  chk_temp_high: assert property (bit_ev && !start_ev && !stop_ev
    && state_q == pressure_fetch_pkg::ST_CTRL_ACK && !bit_val
    && byte_idx_q == `BYTE_PRES_LOW |=> tx_q == cur_q.temp[10:3])
    else $error("temperature high byte wrong");
  chk_temp_low: assert property (bit_ev && !start_ev && !stop_ev
    && state_q == pressure_fetch_pkg::ST_CTRL_ACK && !bit_val
    && byte_idx_q == `BYTE_TEMP_HIGH |=> tx_q[7:5] == cur_q.temp[2:0])
    else $error("temperature low bits wrong");
  chk_keep_sending: assert property (bit_ev && !start_ev && !stop_ev
    && state_q == pressure_fetch_pkg::ST_CTRL_ACK
    |=> state_q == ($past(bit_val) ? pressure_fetch_pkg::ST_IDLE
    : pressure_fetch_pkg::ST_TX))
    else $error("continuation after acknowledge wrong");
  chk_msb_first: assert property (scl_fall && !start_ev && !stop_ev
    && state_q == pressure_fetch_pkg::ST_TX
    |=> sda_oe_o == ~tx_q[$past(bit_cnt_q)])
    else $error("data bit order wrong");
  chk_fault_sticky: assert property (fault_q
    |=> fault_q && status == `STAT_FAULT)
    else $error("fault status dropped");
  chk_pres_range: assert property (
    pres_out >= `NEGATIVE_FULL_SCALE_CODE
    && pres_out <= `POSITIVE_FULL_SCALE_CODE)
    else $error("pressure code outside span");
  chk_stale_code: assert property (pop && !fifo_valid && !fault_q
    && !cmd_mode_i |=> status == `STAT_STALE)
    else $error("stale fetch not flagged");

  cov_two_byte: cover property (state_q == pressure_fetch_pkg::ST_CTRL_ACK
    && bit_ev && bit_val && byte_idx_q == `BYTE_PRES_LOW);
  cov_four_byte: cover property (state_q == pressure_fetch_pkg::ST_CTRL_ACK
    && bit_ev && bit_val && byte_idx_q == `BYTE_TEMP_LOW);
  cov_stale: cover property (pop && !fifo_valid);
  cov_full: cover property (!meas_ready_o && meas_valid_i);

endmodule // pressure_fetch

// ### verification/i2c_ctrl_model.sv
// Behavioural I2C controller that fetches measurement packets
`timescale 1ns/100ps
module i2c_ctrl_model (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // One bit: data set in the low phase, line sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    #40 sda_o = b;
    #40 scl_o = 1'b1;
    #40 r = sda_i;
    #40 scl_o = 1'b0;
  endtask

  // Header, target ACK, n bytes, NACK on the last one, stop
  task automatic fetch(input logic [7:0] hdr, input int n,
                       output logic [39:0] data, output logic ack);
    logic r;
    logic [7:0] b;
    data = '0;
    #40 sda_o = 1'b0;
    #160 scl_o = 1'b0;
    for (int i = 7; i >= 0; i--) bit_io(hdr[i], r);
    bit_io(1'b1, r);
    ack = ~r;
    for (int k = 0; k < n && ack; k++) begin
      for (int i = 0; i < 8; i++) begin
        bit_io(1'b1, r);
        b = {b[6:0], r};
      end
      if (k == 3) b = b & 8'he0;
      data = {data[31:0], b};
      bit_io(k == n - 1, r);
    end
    #40 sda_o = 1'b0;
    #40 scl_o = 1'b1;
    #80 sda_o = 1'b1;
    #2000;
  endtask
endmodule // i2c_ctrl_model

// ### verification/testbench.sv
// Self-checking bench for the pressure fetch target
`timescale 1ns/100ps
`include "pressure_fetch_defines.svh"
module testbench;
  logic clk_i, nrst_i, meas_valid_i, cmd_mode_i, scl, ctl_sda;
  logic sda_o, sda_oe_o, meas_ready_o;
  pressure_fetch_pkg::meas_s meas_i;
  int failures, compares;
  // Open drain wire with pull-up
  wire logic sda_line = ctl_sda & ~(sda_oe_o & ~sda_o);

  pressure_fetch u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .meas_valid_i(meas_valid_i),
    .meas_i(meas_i), .meas_ready_o(meas_ready_o), .cmd_mode_i(cmd_mode_i));
  i2c_ctrl_model u_ctl (.scl_o(scl), .sda_o(ctl_sda), .sda_i(sda_line));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic logic [39:0] pk(input logic [1:0] s,
                                     input logic [13:0] p,
                                     input logic [10:0] t);
    return {s, p, t, 5'h00, 8'h00};
  endfunction

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    #1 nrst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  // Offer a word and hold it until the buffer takes it
  task automatic push(input logic f, input logic [13:0] p,
                      input logic [10:0] t);
    @(posedge clk_i);
    #1;
    meas_valid_i = 1'b1;
    meas_i = {f, p, t};
    for (int i = 0; i < 60000 && meas_ready_o !== 1'b1; i++)
      @(posedge clk_i) #1;
    if (meas_ready_o !== 1'b1) check(40'h0, 40'h1);
    @(posedge clk_i);
    #1 meas_valid_i = 1'b0;
  endtask

  task automatic fetch_chk(input int n, input logic [39:0] full);
    logic [39:0] got;
    logic ack;
    u_ctl.fetch(8'h51, n, got, ack);
    check({39'h0, ack}, 40'h1);
    check(got, full >> (8 * (5 - n)));
  endtask

  task automatic stale_chk();
    logic [39:0] got;
    logic ack;
    u_ctl.fetch(8'h51, 2, got, ack);
    check({38'h0, got[15:14]}, 40'h2);
  endtask

  task automatic t_address();
    logic [7:0] hdr [4] = '{8'h50, 8'h53, 8'h11, 8'hd1};
    logic [39:0] got;
    logic ack;
    foreach (hdr[i]) begin
      u_ctl.fetch(hdr[i], 2, got, ack);
      check({39'h0, ack}, 40'h0);
    end
  endtask

  task automatic t_buffer();
    push(1'b0, 14'h1234, 11'h5a5);
    push(1'b0, 14'h0abc, 11'h123);
    @(posedge clk_i);
    #1 check({39'h0, meas_ready_o}, 40'h0);
    fork
      push(1'b0, 14'h2222, 11'h3ff);
      fetch_chk(5, pk(2'b00, 14'h1234, 11'h5a5));
    join
    fetch_chk(2, pk(2'b00, 14'h0abc, 11'h123));
    fetch_chk(3, pk(2'b00, 14'h2222, 11'h3ff));
    fetch_chk(4, pk(2'b10, 14'h2222, 11'h3ff));
  endtask

  task automatic t_clamp();
    push(1'b0, 14'h0000, 11'h7ff);
    push(1'b0, 14'h3fff, 11'h001);
    fetch_chk(4, pk(2'b00, `NEGATIVE_FULL_SCALE_CODE, 11'h7ff));
    @(posedge clk_i);
    #1 cmd_mode_i = 1'b1;
    fetch_chk(3, pk(2'b01, `POSITIVE_FULL_SCALE_CODE, 11'h001));
    @(posedge clk_i);
    #1 cmd_mode_i = 1'b0;
  endtask

  task automatic t_fault();
    push(1'b1, 14'h1000, 11'h100);
    fetch_chk(2, pk(2'b11, 14'h1000, 11'h100));
    push(1'b0, 14'h2000, 11'h200);
    fetch_chk(4, pk(2'b11, 14'h2000, 11'h200));
    do_reset();
    stale_chk();
  endtask

  initial begin
    nrst_i = 1'b0;
    meas_valid_i = 1'b0;
    cmd_mode_i = 1'b0;
    meas_i = '0;
    failures = 0;
    compares = 0;
    do_reset();
    stale_chk();
    t_address();
    t_buffer();
    t_clamp();
    t_fault();
    close_out();
  end

  // Watchdog: all frames need well under this span
  initial begin
    #400000;
    failures++;
    close_out();
  end
endmodule // testbench
